// File: bench/host_port.sv
// host serial port model: select, shift clock and bit capture
`timescale 1ns/100ps
`default_nettype none
module host_port
(
  input  wire logic                  clk,
  input  wire adc_seq_pkg::dout_type dout,
  input  wire logic                  smp,
  output var  logic                  cs_n,
  output var  logic                  io_clk
);
  import adc_seq_pkg::*;
  initial
  begin
    cs_n = 1'b1;
    io_clk = 1'b0;
  end
  // select change, then hold the new level
  task automatic sel(input logic lvl, input int hold);
    @(posedge clk);
    cs_n <= lvl;
    repeat (hold) @(posedge clk);
  endtask
  // n clocks of 320 ns, clock low between frames
  // gap stretches the high phase of clocks past the tenth
  task automatic xfer(input int n, input int gap,
                      output logic [15:0] bits, output logic [15:0] win);
    bits = 16'h0000;
    win = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      io_clk <= 1'b1;
      repeat (k >= 10 ? gap : 4) @(posedge clk);
      // a released line reads as the inverse of its last driven bit
      bits[15-k] = dout.oe ? dout.data : !dout.data;
      win[15-k] = smp;
      io_clk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench of the converter serial sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  import adc_seq_pkg::*;
  logic             clk = 1'b0;
  logic             resetn;
  logic             res_valid;
  logic [RES_W-1:0] res_data;
  logic             res_ready;
  logic             cs_n;
  logic             io_clk;
  dout_type         dout;
  status_type       status;
  logic [31:0]      st = 32'h0000_c01d;
  logic [RES_W-1:0] q[$];
  logic [RES_W-1:0] res = RES_RESET;
  logic [15:0]      bits;
  logic [15:0]      win;
  logic [15:0]      exp16;
  logic             go = 1'b0;
  int               pushed = 0;
  int               error_cnt = 0;
  int               checks_done = 0;
  int               cycles = 0;
  int               holds = 0;
  int               holds_exp = 0;
  int               n;

  always #20 clk = ~clk;

  adc_seq u_dut
  (
    .clk       (clk),
    .resetn    (resetn),
    .cs_n      (cs_n),
    .io_clk    (io_clk),
    .res_valid (res_valid),
    .res_ready (res_ready),
    .res_data  (res_data),
    .dout      (dout),
    .status    (status)
  );

  host_port u_host
  (
    .clk    (clk),
    .dout   (dout),
    .smp    (status.sampling),
    .cs_n   (cs_n),
    .io_clk (io_clk)
  );

  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction

  // transfer over before the 21 us conversion completes
  function automatic logic fast_xfer(input int cnt, input int gap);
    return (cnt - 10) * (gap + 4) + 4 <= CONV_CYCLES;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // eighteen words offered, so the fifo fills and refuses
  always @(posedge clk)
  begin
    cycles++;
    if (status.hold === 1'b1)
      holds++;
    if (res_valid && res_ready === 1'b1)
    begin
      q.push_back(res_data);
      pushed++;
      res_data <= RES_W'(rnd());
    end
    res_valid <= go && (pushed < 18);
    if (cycles == 60000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // one frame, result compare, then the conversion wait
  task automatic run_xfer(input int cnt, input int gap);
    u_host.xfer(cnt, gap, bits, win);
    holds_exp++;
    exp16 = {res, 6'h00};
    `CHK("result bits", exp16, bits)
    `CHK("sample window", 16'h1fc0, win)
    @(posedge clk);
    `CHK("converting", fast_xfer(cnt, gap), status.converting)
    repeat (599) @(posedge clk);
    `CHK("window closed", 1'b0, status.sampling)
    `CHK("hold pulses", holds_exp, holds)
    if (q.size() > 0)
      res = q.pop_front();
  endtask

  task automatic toggled(input int cnt, input int gap);
    u_host.sel(1'b0, 40);
    `CHK("oe on fall", 1'b1, dout.oe)
    run_xfer(cnt, gap);
    u_host.sel(1'b1, 40);
    `CHK("oe on rise", 1'b0, dout.oe)
  endtask

  initial
  begin
    resetn = 1'b0;
    res_valid = 1'b0;
    res_data = RES_W'(rnd());
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    go <= 1'b1;
    u_host.xfer(3, 4, bits, win);
    `CHK("oe while high", 1'b0, dout.oe)
    repeat (30) @(posedge clk);
    `CHK("fifo full", 1'b0, res_ready)
    // modes 1, 3 and 5: corners first, then random lengths
    for (int i = 0; i < 16; i++)
    begin
      n = (i < 2) ? 10 + 6 * i : 10 + int'(rnd() % 7);
      toggled(n, (rnd() % 2 == 0) ? 110 : 4);
    end
    // abort mid-conversion keeps the old result
    u_host.sel(1'b0, 40);
    u_host.xfer(10, 4, bits, win);
    holds_exp++;
    repeat (100) @(posedge clk);
    u_host.sel(1'b1, 40);
    u_host.sel(1'b0, 40);
    run_xfer(10, 4);
    u_host.sel(1'b1, 40);
    // short select pulse: rise ignored inside lockout
    u_host.sel(1'b0, 10);
    u_host.sel(1'b1, 19);
    `CHK("lockout", 1'b1, dout.oe)
    repeat (30) @(posedge clk);
    `CHK("late rise", 1'b0, dout.oe)
    // continuous select: modes 4, 2, 6
    u_host.sel(1'b0, 40);
    run_xfer(16, 4);
    run_xfer(10, 4);
    `CHK("fast flag", 1'b0, status.slow)
    run_xfer(16, 110);
    `CHK("slow flag", 1'b1, status.slow)
    run_xfer(16, 4);
    u_host.sel(1'b1, 40);
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/adc_seq.sv
// result fifo and serial interface sequencer of the converter
`timescale 1ns/100ps
`default_nettype none

module result_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = count_q != '0;
  assign out_data  = mem[rd_q];
  assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q     <= '0;
      rd_q     <= '0;
      count_q  <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wr_q     <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q     <= pop ? AW'(rd_q + 1'b1) : rd_q;
      count_q  <= count_d;
      in_ready <= count_d != (AW+1)'(DEPTH);
    end
  end
endmodule

// Summary of operation
// R1 - select high: shift clock ignored, serial output high impedance.
// R2 - select falling: clock counting enabled, serial output driven.
// R3 - host gives 10 to 16 clocks; first ten time the sampling.
// R4 - conversion starts only on the tenth falling clock edge.
// R5 - toggled select modes: previous msb shown when select falls.
// R6 - continuous fast modes: msb shown within 21 us of tenth edge.
// R7 - continuous slow mode: output leaves forced low on sixteenth edge.
// R8 - nine more bits follow on the next nine falling edges.
// R9 - tenth falling edge forces output low; extra clocks give zeros.
// R10 - host waits 21 us after tenth edge before a new transfer.
// R11 - host keeps select low throughout a clock transfer.
// R12 - select edge valid only if level persists 1.425 us; the code acts on an edge at once, then locks out further edges for that time.
// R13 - host raises eleventh clock within 9.5 us of tenth edge.
// R14 - fast transfer ends within 21 us of the tenth edge.
// R15 - slow transfer ends later than 21 us after the tenth edge.
// R16 - select rising ends sequence, output high impedance, clock off.
// R17 - continuous modes: host keeps select low for later conversions.
// R18 - continuous modes 4 and 6 use exactly 16 clocks.
// R19 - toggled modes 3 and 5 use 11 to 16 clocks.
// R20 - host should never exceed 16 clocks in a transfer.
// R21 - sampling from third to tenth falling edge, held on tenth.
// R22 - after a ten clock mode 1 transfer, ready for next select fall.
// R23 - select falling resets counters and control state.
// R24 - tenth falling edge hands conversion to the internal timer.
// R25 - select falling aborts a running conversion, keeping old result.
// R26 - result register loads only when a conversion completes.
module adc_seq
(
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           cs_n,
  input  wire logic                           io_clk,
  input  wire logic                           res_valid,
  output var  logic                           res_ready,
  input  wire logic [adc_seq_pkg::RES_W-1:0]  res_data,
  output var  adc_seq_pkg::dout_type          dout,
  output var  adc_seq_pkg::status_type        status
);
  import adc_seq_pkg::*;

  logic                rst_m_q;
  logic                rst_n_q;
  logic                cs_m_q;
  logic                cs_s_q;
  logic                ck_m_q;
  logic                ck_s_q;
  logic                ck_d_q;
  logic                cs_acc_q;
  logic [LOCK_W-1:0]   lock_q;
  seq_state_type       state_q;
  seq_state_type       state_d;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;
  logic [CNT_W-1:0]    cnt_inc;
  logic [RES_W-1:0]    sh_q;
  logic [RES_W-1:0]    sh_d;
  logic [RES_W-1:0]    res_q;
  logic [RES_W-1:0]    new_res;
  logic [CONV_W-1:0]   conv_q;
  logic                busy_q;
  logic                sample_q;
  logic                hold_q;
  logic                slow_q;
  logic                accept;
  logic                cs_fall;
  logic                cs_rise;
  logic                io_fall;
  logic                conv_start;
  logic                done;
  logic                present_now;
  logic                go_slow;
  logic                release16;
  logic                fifo_valid;
  logic [RES_W-1:0]    fifo_data;

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      ck_m_q <= 1'b0;
      ck_s_q <= 1'b0;
      ck_d_q <= 1'b0;
    end
    else
    begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
      ck_m_q <= io_clk;
      ck_s_q <= ck_m_q;
      ck_d_q <= ck_s_q;
    end
  end

  // select edges accepted, then locked out for the minimum hold time
  assign accept  = (cs_s_q != cs_acc_q) && (lock_q == '0); // [R12]
  assign cs_fall = accept && !cs_s_q;
  assign cs_rise = accept && cs_s_q;
  // clock edges only count while a sequence is open
  assign io_fall = ck_d_q && !ck_s_q && (state_q != s_idle); // [R1]

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cs_acc_q <= 1'b1;
      lock_q   <= '0;
    end
    else
    begin
      cs_acc_q <= accept ? cs_s_q : cs_acc_q;
      lock_q   <= accept ? LOCK_W'(CS_LOCK_CYCLES - 1) :
                  (lock_q != '0) ? LOCK_W'(lock_q - 1'b1) : lock_q; // [R12]
    end
  end

  assign cnt_inc    = (cnt_q == EDGE_LAST) ? cnt_q : CNT_W'(cnt_q + 1'b1);
  assign conv_start = io_fall && (state_q == s_active) && !accept &&
                      (cnt_inc == EDGE_HOLD); // [R4] [R24]
  assign done       = busy_q && (conv_q == '0) && !cs_fall;
  assign new_res    = fifo_valid ? fifo_data : res_q;
  // fast when completion finds the count on the tenth or sixteenth edge, slow between
  assign present_now = done && (state_q == s_active) && !cs_rise &&
                       ((cnt_q == EDGE_HOLD) || (cnt_q == EDGE_LAST)); // [R14]
  assign go_slow    = done && (state_q == s_active) && !cs_rise &&
                      (cnt_q > EDGE_HOLD) && (cnt_q < EDGE_LAST); // [R15]
  assign release16  = (state_q == s_wait16) && io_fall && !accept &&
                      (cnt_inc == EDGE_LAST);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    if (cs_fall)
    begin
      state_d = s_active; // [R2] [R23] [R25]
      cnt_d   = EDGE_NONE;
      sh_d    = res_q; // [R5]
    end
    else if (cs_rise)
      state_d = s_idle; // [R16] [R22]
    else
    begin
      if (io_fall)
      begin
        cnt_d = cnt_inc;
        sh_d  = {sh_q[RES_W-2:0], 1'b0}; // [R8] [R9]
      end
      if (present_now)
      begin
        cnt_d = EDGE_NONE;
        sh_d  = new_res; // [R6]
      end
      else if (go_slow)
        state_d = s_wait16;
      if (release16)
      begin
        state_d = s_active;
        cnt_d   = EDGE_NONE;
        sh_d    = res_q; // [R7]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= s_idle;
      cnt_q   <= EDGE_NONE;
      sh_q    <= RES_RESET;
      dout    <= '{data: 1'b0, oe: 1'b0};
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      dout    <= '{data: sh_d[RES_W-1], oe: state_d != s_idle}; // [R1] [R2]
    end
  end

  // conversion timer, less the edge latency so the result lands by 21 us
  // a new select fall aborts it
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      busy_q <= 1'b0;
      conv_q <= '0;
      res_q  <= RES_RESET;
    end
    else
    begin
      busy_q <= conv_start || (busy_q && !done && !cs_fall); // [R25]
      conv_q <= conv_start ? CONV_W'(CONV_CYCLES - FALL_LAT) : // [R6]
                (conv_q != '0) ? CONV_W'(conv_q - 1'b1) : conv_q;
      res_q  <= done ? new_res : res_q; // [R26]
    end
  end

  // sampling window and status flags
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sample_q <= 1'b0;
      hold_q   <= 1'b0;
      slow_q   <= 1'b0;
    end
    else
    begin
      sample_q <= (io_fall && !accept && (state_q == s_active) &&
                   (cnt_inc == EDGE_SAMPLE)) ||
                  (sample_q && !conv_start && !accept); // [R21]
      hold_q   <= conv_start;
      slow_q   <= go_slow || (slow_q && !present_now);
    end
  end

  assign status = '{sampling: sample_q, hold: hold_q,
                    converting: busy_q, slow: slow_q};

  result_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n_q),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (fifo_valid),
    .out_ready (done),
    .out_data  (fifo_data)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_q);

  property p_idle_hiz;
    (state_q == s_idle) && !accept |=> !dout.oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) // [R1]
    else $error("output driven while select high");

  property p_fall_msb;
    cs_fall |=> dout.oe && (dout.data == $past(res_q[RES_W-1]))
                && (cnt_q == EDGE_NONE);
  endproperty
  a_fall_msb: assert property (p_fall_msb) // [R5]
    else $error("msb not shown on select fall");

  property p_rise_off;
    cs_rise |=> !dout.oe ##1 !dout.oe;
  endproperty
  a_rise_off: assert property (p_rise_off) // [R16]
    else $error("output still driven after select rise");

  property p_conv_tenth;
    conv_start |-> (cnt_q == 5'h09) ##1 (busy_q && hold_q && !sample_q);
  endproperty
  a_conv_tenth: assert property (p_conv_tenth) // [R24]
    else $error("conversion not started on tenth edge");

  property p_shift;
    io_fall && (state_q == s_active) && !accept && !done |=>
      sh_q == {$past(sh_q[RES_W-2:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) // [R8]
    else $error("result bit not shifted on falling edge");

  property p_zero_fill;
    (state_q != s_idle) && (cnt_q >= EDGE_HOLD) |-> !dout.data;
  endproperty
  a_zero_fill: assert property (p_zero_fill) // [R9]
    else $error("nonzero output after tenth edge");

  property p_release16;
    release16 |=> (state_q == s_active) &&
                  (dout.data == $past(res_q[RES_W-1]));
  endproperty
  a_release16: assert property (p_release16) // [R7]
    else $error("output not released on sixteenth edge");

  property p_fast_msb;
    present_now |=> (dout.data == $past(new_res[RES_W-1])) &&
                    (cnt_q == EDGE_NONE) && (res_q == $past(new_res));
  endproperty
  a_fast_msb: assert property (p_fast_msb) // [R6]
    else $error("fast mode msb not presented at completion");

  property p_load_only_done;
    $changed(res_q) |-> $past(done);
  endproperty
  a_load_only_done: assert property (p_load_only_done) // [R26]
    else $error("result register changed without completion");

  property p_abort;
    cs_fall && busy_q |=> !busy_q && (res_q == $past(res_q));
  endproperty
  a_abort: assert property (p_abort) // [R25]
    else $error("select fall did not abort conversion");

  property p_lockout;
    accept |=> !accept [*8];
  endproperty
  a_lockout: assert property (p_lockout) // [R12]
    else $error("select edge accepted inside hold time");

  property p_sample_start;
    io_fall && !accept && (state_q == s_active) &&
      (cnt_q == 5'h02) |=> sample_q;
  endproperty
  a_sample_start: assert property (p_sample_start) // [R21]
    else $error("sampling not started on third edge");

  c_toggled: cover property (cs_fall ##[1:1000] done);
  c_slow: cover property (go_slow ##[1:300] release16);
  c_fast: cover property (present_now);
  c_fifo_full: cover property (!res_ready);
endmodule
`default_nettype wire

// File: verilog/adc_seq_pkg.sv
// constants, states and carriers for the serial converter sequencer
`default_nettype none
package adc_seq_pkg;
  localparam int RES_W         = 10;
  localparam int FIFO_DEPTH    = 16;
  localparam int CNT_W         = 5;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 21000;
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_W        = 10;
  // cycles from a pin fall to the timer load, plus the output register
  localparam int FALL_LAT      = 4;
  localparam int CS_HOLD_NS    = 1425;
  localparam int CS_LOCK_CYCLES =
    (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_W        = 6;

  localparam logic [CNT_W-1:0] EDGE_NONE   = 5'h00;
  localparam logic [CNT_W-1:0] EDGE_SAMPLE = 5'h03;
  localparam logic [CNT_W-1:0] EDGE_HOLD   = 5'h0a;
  localparam logic [CNT_W-1:0] EDGE_LAST   = 5'h10;
  localparam logic [RES_W-1:0] RES_RESET   = 10'h000;

  typedef enum logic [1:0] {s_idle, s_active, s_wait16} seq_state_type;

  typedef struct packed {
    logic data;
    logic oe;
  } dout_type;

  typedef struct packed {
    logic sampling;
    logic hold;
    logic converting;
    logic slow;
  } status_type;
endpackage
`default_nettype wire
